// ===== rtl/abx_exec.sv
// Execute datapath for add, AND and bit operations of an 8-bit core
`timescale 1ns/1ps
`default_nettype none
module abx_exec (
  input wire logic CLK, // Core clock, 200 MHz
  input wire logic NRST, // Asynchronous reset, active low
  input wire logic ISSUE, // Instruction valid this cycle
  input wire abx_pkg::abx_instr_t INSTR, // Decoded instruction fields
  input wire logic [7:0] REG_RDATA, // Register file read data at INSTR.addr
  input wire logic IS_PORT, // Addressed register is an I/O port
  input wire logic [7:0] PIN_LEVEL, // Pin levels of the addressed port
  output logic [7:0] ACC, // Accumulator
  output logic [2:0] FLAGS, // Carry, half carry, zero
  output abx_pkg::abx_wr_t REG_WR, // Register write-back
  output logic SKIP, // Discard next fetched instruction
  output logic BUSY // Second, no-op cycle in progress
);
  import abx_pkg::*;

  logic rst_s1_q, rst_s2_q; // Reset release synchroniser
  logic rst_n;
  logic [7:0] acc_q, acc_d;
  logic [2:0] flags_q, flags_d;
  abx_wr_t wr_q, wr_d;
  logic skip_q, skip_d;
  logic [7:0] opnd; // Register operand
  logic [8:0] sum; // Adder with carry out
  logic [4:0] low_sum; // Low nibble adder
  logic [7:0] res; // Logic/arith result
  logic tbit; // Tested bit
  logic go; // Instruction accepted
  logic fwd_hit; // Pending write-back matches the read address

  // Zero detection used by every flag-updating path
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Two-flop reset release
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // No issue is taken while the inserted no-op runs
  assign go = ISSUE && !skip_q; // RULE12
  // Write-back lands in the register file one edge late, so a read of
  // the address just written must take the pending value instead
  assign fwd_hit = wr_q.we && (wr_q.addr == INSTR.addr);
  // Port registers are read from the pins, others from the latch
  assign opnd = IS_PORT ? PIN_LEVEL : (fwd_hit ? wr_q.data : REG_RDATA); // RULE13 RULE14
  // Second operand: immediate or register
  assign sum = {1'b0, acc_q} + {1'b0, (INSTR.op == ABX_OP_ADD_IMM) ? INSTR.imm : opnd};
  assign low_sum = {1'b0, acc_q[3:0]}
                 + {1'b0, (INSTR.op == ABX_OP_ADD_IMM) ? INSTR.imm[3:0] : opnd[3:0]};
  assign tbit = opnd[INSTR.bit_sel];

  // Result, destination and flag computation
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    wr_d = '0;
    skip_d = 1'b0;
    res = 8'h00;
    if (go) begin
      case (INSTR.op)
        ABX_OP_ADD_IMM, ABX_OP_ADD_REG: begin
          res = sum[7:0]; // RULE1 RULE2
          flags_d[FLAG_CARRY] = sum[8];
          flags_d[FLAG_HALF] = low_sum[4];
          flags_d[FLAG_ZERO] = is_zero(res); // RULE15
        end
        ABX_OP_AND_IMM: begin
          res = acc_q & INSTR.imm; // RULE4
          flags_d[FLAG_ZERO] = is_zero(res); // RULE15
        end
        ABX_OP_AND_REG: begin
          res = acc_q & opnd; // RULE5
          flags_d[FLAG_ZERO] = is_zero(res); // RULE15
        end
        ABX_OP_BIT_CLR: begin
          res = opnd & ~(8'h01 << INSTR.bit_sel); // RULE6 RULE14
        end
        ABX_OP_BIT_SET: begin
          res = opnd | (8'h01 << INSTR.bit_sel); // RULE7 RULE14
        end
        ABX_OP_TST_SET: begin
          skip_d = tbit; // RULE8 RULE9
        end
        ABX_OP_TST_CLR: begin
          skip_d = !tbit; // RULE10 RULE11
        end
        default: begin
          res = 8'h00;
        end
      endcase
      // Destination routing
      case (INSTR.op)
        ABX_OP_ADD_IMM, ABX_OP_AND_IMM: begin
          acc_d = res; // RULE1 RULE4
        end
        ABX_OP_ADD_REG, ABX_OP_AND_REG: begin
          if (INSTR.dest_reg) begin
            wr_d = '{we: 1'b1, addr: INSTR.addr, data: res}; // RULE3 RULE14
          end else begin
            acc_d = res; // RULE3
          end
        end
        ABX_OP_BIT_CLR, ABX_OP_BIT_SET: begin
          wr_d = '{we: 1'b1, addr: INSTR.addr, data: res}; // RULE14
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // Accumulator and flags
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RESET;
      flags_q <= FLAGS_RESET;
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
    end
  end

  // Write-back and skip pipeline
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      skip_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      skip_q <= skip_d; // RULE9 RULE11
    end
  end

  assign ACC = acc_q;
  assign FLAGS = flags_q;
  assign REG_WR = wr_q;
  assign SKIP = skip_q;
  assign BUSY = skip_q;

  // Skip sequence: true test then one no-op cycle
  sequence s_tst_true;
    go && ((INSTR.op == ABX_OP_TST_SET && tbit) || (INSTR.op == ABX_OP_TST_CLR && !tbit));
  endsequence
  sequence s_noop_then_free;
    SKIP ##1 !SKIP;
  endsequence

  a_skip_two_cycles: assert property (@(posedge CLK) disable iff (!rst_n) // RULE9 RULE11 RULE12
    s_tst_true |=> s_noop_then_free) else $error("true bit test did not insert one no-op");
  a_no_skip_false: assert property (@(posedge CLK) disable iff (!rst_n) // RULE8 RULE10
    go && ((INSTR.op == ABX_OP_TST_SET && !tbit) || (INSTR.op == ABX_OP_TST_CLR && tbit))
    |=> !SKIP) else $error("false bit test caused a skip");
  a_add_imm_acc: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1
    go && INSTR.op == ABX_OP_ADD_IMM |=> ACC == $past(acc_q) + $past(INSTR.imm)
    && FLAGS[FLAG_CARRY] == $past(sum[8])) else $error("add immediate result wrong");
  a_dest_select: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
    go && (INSTR.op == ABX_OP_ADD_REG || INSTR.op == ABX_OP_AND_REG) && INSTR.dest_reg
    |=> REG_WR.we && ACC == $past(acc_q)) else $error("register destination misrouted");
  a_and_flags: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4 RULE5
    go && (INSTR.op == ABX_OP_AND_IMM || INSTR.op == ABX_OP_AND_REG)
    |=> FLAGS[2:1] == $past(flags_q[2:1])) else $error("AND altered carry flags");
  a_bit_flags: assert property (@(posedge CLK) disable iff (!rst_n) // RULE6 RULE7
    go && (INSTR.op == ABX_OP_BIT_CLR || INSTR.op == ABX_OP_BIT_SET)
    |=> FLAGS == $past(flags_q) && REG_WR.we
    && REG_WR.data[$past(INSTR.bit_sel)] == ($past(INSTR.op) == ABX_OP_BIT_SET))
    else $error("bit operation wrong");
  a_zero_flag: assert property (@(posedge CLK) disable iff (!rst_n) // RULE15
    go && INSTR.op inside {ABX_OP_ADD_IMM, ABX_OP_ADD_REG, ABX_OP_AND_IMM, ABX_OP_AND_REG}
    |=> FLAGS[FLAG_ZERO] == (REG_WR.we ? REG_WR.data == 8'h00 : ACC == 8'h00))
    else $error("zero flag mismatch");
  a_port_pins: assert property (@(posedge CLK) disable iff (!rst_n) // RULE13
    go && IS_PORT && INSTR.op == ABX_OP_BIT_SET
    |=> REG_WR.data == ($past(PIN_LEVEL) | (8'h01 << $past(INSTR.bit_sel))))
    else $error("port operand not from pins");

  // Helper sequences for the per-operation checks
  sequence s_take_add;
    go && (INSTR.op == ABX_OP_ADD_IMM || INSTR.op == ABX_OP_ADD_REG);
  endsequence
  sequence s_take_bit;
    go && (INSTR.op == ABX_OP_BIT_CLR || INSTR.op == ABX_OP_BIT_SET);
  endsequence
  sequence s_take_test;
    go && (INSTR.op == ABX_OP_TST_SET || INSTR.op == ABX_OP_TST_CLR);
  endsequence
  sequence s_all_held;
    ACC == $past(acc_q) && FLAGS == $past(flags_q) && !REG_WR.we;
  endsequence

  // An issue during the inserted no-op changes nothing
  a_busy_ignores: assert property (@(posedge CLK) disable iff (!rst_n) // RULE12
    ISSUE && BUSY
    |=> s_all_held)
    else $error("issue taken during the no-op cycle");

  // The skip request stands for exactly one cycle
  a_skip_pulse: assert property (@(posedge CLK) disable iff (!rst_n) // RULE9 RULE11
    SKIP
    |=> !SKIP && !BUSY)
    else $error("skip held past one cycle");

  // Busy always mirrors the skip request
  a_busy_mirror: assert property (@(posedge CLK) disable iff (!rst_n) // RULE12
    SKIP || BUSY
    |-> SKIP && BUSY)
    else $error("busy and skip disagree");

  // Nothing moves when no instruction is taken
  a_idle_quiet: assert property (@(posedge CLK) disable iff (!rst_n) // RULE12
    !go
    |=> s_all_held ##0 !SKIP)
    else $error("state changed with no instruction");

  // Add to accumulator never writes back or skips
  a_add_no_write: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1 RULE3
    s_take_add ##0 (INSTR.op == ABX_OP_ADD_IMM || !INSTR.dest_reg)
    |=> !REG_WR.we && !SKIP)
    else $error("add to accumulator wrote back");

  // Carry of the register add is the ninth sum bit
  a_add_reg_carry: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
    go && INSTR.op == ABX_OP_ADD_REG
    |=> FLAGS[FLAG_CARRY] == (({1'b0, $past(acc_q)} + {1'b0, $past(opnd)}) > 9'h0FF))
    else $error("register add carry wrong");

  // Half carry of the immediate add comes out of bit 3
  a_add_imm_half: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1
    go && INSTR.op == ABX_OP_ADD_IMM
    |=> FLAGS[FLAG_HALF] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(INSTR.imm[3:0])}) > 5'h0F))
    else $error("immediate add half carry wrong");

  // Half carry of the register add comes out of bit 3
  a_add_reg_half: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2
    go && INSTR.op == ABX_OP_ADD_REG
    |=> FLAGS[FLAG_HALF] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(opnd[3:0])}) > 5'h0F))
    else $error("register add half carry wrong");

  // Zero flag of the immediate add
  a_add_imm_zero: assert property (@(posedge CLK) disable iff (!rst_n) // RULE1 RULE15
    go && INSTR.op == ABX_OP_ADD_IMM
    |=> FLAGS[FLAG_ZERO] == (8'($past(acc_q) + $past(INSTR.imm)) == 8'h00))
    else $error("immediate add zero flag wrong");

  // Register add into the accumulator
  a_add_reg_acc: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2 RULE3
    go && INSTR.op == ABX_OP_ADD_REG && !INSTR.dest_reg
    |=> ACC == 8'($past(acc_q) + $past(opnd)) && !REG_WR.we)
    else $error("register add to accumulator wrong");

  // Register add written back to its own address
  a_add_reg_wr: assert property (@(posedge CLK) disable iff (!rst_n) // RULE2 RULE3 RULE14
    go && INSTR.op == ABX_OP_ADD_REG && INSTR.dest_reg
    |=> REG_WR.data == 8'($past(acc_q) + $past(opnd)) && REG_WR.addr == $past(INSTR.addr))
    else $error("register add write-back wrong");

  // AND immediate lands in the accumulator
  a_and_imm_acc: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4
    go && INSTR.op == ABX_OP_AND_IMM
    |=> ACC == ($past(acc_q) & $past(INSTR.imm)))
    else $error("AND immediate result wrong");

  // Zero flag of the AND immediate
  a_and_imm_zero: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4 RULE15
    go && INSTR.op == ABX_OP_AND_IMM
    |=> FLAGS[FLAG_ZERO] == (($past(acc_q) & $past(INSTR.imm)) == 8'h00))
    else $error("AND immediate zero flag wrong");

  // AND register into the accumulator
  a_and_reg_acc: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3 RULE5
    go && INSTR.op == ABX_OP_AND_REG && !INSTR.dest_reg
    |=> ACC == ($past(acc_q) & $past(opnd)) && !REG_WR.we)
    else $error("AND register to accumulator wrong");

  // AND register written back, accumulator kept
  a_and_reg_wr: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5 RULE14
    go && INSTR.op == ABX_OP_AND_REG && INSTR.dest_reg
    |=> REG_WR.data == ($past(acc_q) & $past(opnd)) && ACC == $past(acc_q))
    else $error("AND register write-back wrong");

  // Bit clear keeps the other seven bits
  a_bit_clr_rest: assert property (@(posedge CLK) disable iff (!rst_n) // RULE6 RULE14
    go && INSTR.op == ABX_OP_BIT_CLR
    |=> (REG_WR.data | (8'h01 << $past(INSTR.bit_sel)))
        == ($past(opnd) | (8'h01 << $past(INSTR.bit_sel))))
    else $error("bit clear disturbed other bits");

  // Bit set keeps the other seven bits
  a_bit_set_rest: assert property (@(posedge CLK) disable iff (!rst_n) // RULE7 RULE14
    go && INSTR.op == ABX_OP_BIT_SET
    |=> (REG_WR.data & ~(8'h01 << $past(INSTR.bit_sel)))
        == ($past(opnd) & ~(8'h01 << $past(INSTR.bit_sel))))
    else $error("bit set disturbed other bits");

  // Bit operations leave the accumulator and hit their own address
  a_bit_keep_acc: assert property (@(posedge CLK) disable iff (!rst_n) // RULE6 RULE7
    s_take_bit
    |=> ACC == $past(acc_q) && REG_WR.addr == $past(INSTR.addr) && !SKIP)
    else $error("bit operation touched accumulator");

  // Bit tests change no state of their own
  a_test_quiet: assert property (@(posedge CLK) disable iff (!rst_n) // RULE8 RULE10
    s_take_test
    |=> s_all_held)
    else $error("bit test altered state");

  // AND with a port register uses the pin levels
  a_port_and: assert property (@(posedge CLK) disable iff (!rst_n) // RULE13
    go && IS_PORT && INSTR.op == ABX_OP_AND_REG && !INSTR.dest_reg
    |=> ACC == ($past(acc_q) & $past(PIN_LEVEL)))
    else $error("port AND not from pins");

  // A read right after a write to the same address sees the new value
  a_fwd_pending: assert property (@(posedge CLK) disable iff (!rst_n) // RULE14
    go && !IS_PORT && INSTR.op == ABX_OP_BIT_SET && wr_q.we && wr_q.addr == INSTR.addr
    |=> REG_WR.data == ($past(wr_q.data) | (8'h01 << $past(INSTR.bit_sel))))
    else $error("pending write-back not used");
endmodule
`default_nettype wire

// ===== rtl/abx_pkg.sv
// Package for the accumulator and bit-operation execute datapath
// Operation
// RULE1: Add immediate into accumulator, flags carry/half/zero
// RULE2: Add register to accumulator, flags carry/half/zero
// RULE3: Destination select zero accumulator, one register
// RULE4: AND immediate into accumulator, zero flag only
// RULE5: AND register to destination, zero flag only
// RULE6: Bit clear in register, flags untouched
// RULE7: Bit set in register, flags untouched
// RULE8: Skip-if-set: tested zero runs next normally
// RULE9: Skip-if-set: tested one inserts no-op cycle
// RULE10: Skip-if-clear: tested one runs next normally
// RULE11: Skip-if-clear: tested zero inserts no-op cycle
// RULE12: True conditional test takes two cycles
// RULE13: Port register operand read from pins
// RULE14: Full byte read-modify-write in one cycle
// RULE15: Zero flag set exactly when result zero
package abx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_CARRY = 2;
  localparam int SKIP_CYCLES = 1;

  // Operation codes presented by the decoder
  typedef enum logic [3:0] {
    ABX_OP_NONE,
    ABX_OP_ADD_IMM,
    ABX_OP_ADD_REG,
    ABX_OP_AND_IMM,
    ABX_OP_AND_REG,
    ABX_OP_BIT_CLR,
    ABX_OP_BIT_SET,
    ABX_OP_TST_SET,
    ABX_OP_TST_CLR
  } abx_op_t;

  // One issued instruction
  typedef struct packed {
    abx_op_t op;
    logic [7:0] imm;
    logic [6:0] addr;
    logic [2:0] bit_sel;
    logic dest_reg;
  } abx_instr_t;

  // Register file write request
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } abx_wr_t;
endpackage

// ===== verification/abx_exec_tb.sv
// Self-checking bench for the execute datapath
`timescale 1ns/1ps
`default_nettype none
module abx_exec_tb;
  import abx_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    logic [2:0] fl;
    logic we;
    logic [7:0] wd;
    logic sk;
  } abx_exp_t;
  logic CLK = 0, NRST = 0, ISSUE = 0; // Clock, reset, valid
  abx_instr_t INSTR = '0; // Instruction
  logic [7:0] rdata, pins, ACC; // Reads, accumulator
  logic is_port, SKIP, BUSY; // Port, skip
  logic [2:0] FLAGS; // Flags
  abx_wr_t REG_WR; // Write-back
  abx_exp_t q[$], e, m; // Notes
  logic [7:0] racc = ACC_RESET; // Model accumulator
  logic [2:0] rfl = FLAGS_RESET; // Model flags
  logic lw_we = 1'b0; // Previous instruction wrote back
  logic [6:0] lw_a = 7'h00; // Its address
  logic [7:0] lw_d = 8'h00; // Its data, not yet in the file
  int n_mismatch = 0, num_checks = 0, seed = 95;
  initial forever #2.5 CLK = ~CLK;
  abx_exec uut (.CLK(CLK), .NRST(NRST), .ISSUE(ISSUE), .INSTR(INSTR),
    .REG_RDATA(rdata), .IS_PORT(is_port), .PIN_LEVEL(pins), .ACC(ACC),
    .FLAGS(FLAGS), .REG_WR(REG_WR), .SKIP(SKIP), .BUSY(BUSY));
  abx_rf_model rf (.clk(CLK), .addr(INSTR.addr), .wr(REG_WR),
    .rdata(rdata), .is_port(is_port), .pins(pins));
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    num_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %0t: %h not %h", $time, s, x);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Drive one instruction and note its result
  task automatic iss(input abx_op_t op, input logic [7:0] k,
      input logic [6:0] a, input logic [2:0] b, input logic d);
    logic [7:0] o, r;
    logic c, h;
    @(posedge CLK);
    ISSUE <= 1'b1;
    INSTR <= '{op, k, a, b, d};
    @(negedge CLK);
    o = (op == ABX_OP_ADD_IMM || op == ABX_OP_AND_IMM) ? k
      : (is_port ? pins : ((lw_we && lw_a == a) ? lw_d : rdata));
    {c, r} = {1'b0, racc} + {1'b0, o};
    h = (racc[3:0] + o[3:0]) > 5'h0F;
    e = '{racc, rfl, 1'b0, 8'h00, 1'b0};
    case (op)
      ABX_OP_ADD_IMM, ABX_OP_ADD_REG: rfl = {c, h, r == 8'h00};
      ABX_OP_AND_IMM, ABX_OP_AND_REG: begin
        r = racc & o;
        rfl[FLAG_ZERO] = r == 8'h00;
      end
      ABX_OP_BIT_CLR: r = o & ~(8'h01 << b);
      ABX_OP_BIT_SET: r = o | (8'h01 << b);
      default: e.sk = o[b] ~^ (op == ABX_OP_TST_SET);
    endcase
    if (op == ABX_OP_BIT_CLR || op == ABX_OP_BIT_SET || (op < ABX_OP_BIT_CLR && d && (op == ABX_OP_ADD_REG || op == ABX_OP_AND_REG))) begin
      e.we = 1'b1;
      e.wd = r;
    end else if (op < ABX_OP_BIT_CLR) racc = r;
    e.acc = racc;
    e.fl = rfl;
    q.push_back(e);
    lw_we = e.we;
    lw_a = a;
    lw_d = e.wd;
    // Hold a request through the no-op cycle; it must be ignored
    if (e.sk) begin
      @(posedge CLK);
      INSTR.op <= ABX_OP_ADD_IMM;
    end
  endtask
  // Compare each result at the falling edge after the edge that takes it
  always @(posedge CLK) if (ISSUE && BUSY !== 1'b1) begin
    @(negedge CLK);
    m = q.pop_front();
    chk(ACC, m.acc);
    chk({5'h00, FLAGS}, {5'h00, m.fl});
    chk({7'h00, REG_WR.we}, {7'h00, m.we});
    if (m.we) chk(REG_WR.data, m.wd);
    chk({6'h00, SKIP, BUSY}, {6'h00, m.sk, m.sk});
  end
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    chk({FLAGS, 5'h00} ^ ACC, 8'h00);
    iss(ABX_OP_ADD_IMM, 8'hFF, 7'h10, 3'h0, 1'b0);
    iss(ABX_OP_ADD_IMM, 8'h01, 7'h10, 3'h0, 1'b0);
    iss(ABX_OP_BIT_SET, 8'h00, 7'h01, 3'h7, 1'b1);
    iss(ABX_OP_TST_SET, 8'h00, 7'h01, 3'h7, 1'b0);
    $display("directed test done");
    repeat (300) iss(abx_op_t'(4'h1 + 4'($unsigned($random(seed)) % 8)),
      8'($random(seed)), 7'($random(seed)), 3'($random(seed)), 1'($random(seed)));
    @(posedge CLK);
    ISSUE <= 1'b0;
    repeat (3) @(posedge CLK);
    $display("random test done");
    conclude();
  end
  // Watchdog
  initial begin
    #10000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire

// ===== verification/abx_rf_model.sv
// Register file and port pin model
`timescale 1ns/1ps
`default_nettype none
module abx_rf_model (
  input wire logic clk, // Clock
  input wire logic [6:0] addr, // Read address
  input wire abx_pkg::abx_wr_t wr, // Write-back
  output logic [7:0] rdata, // Latch value
  output logic is_port, // Port at 0 and 1
  output logic [7:0] pins // Pin levels
);
  import abx_pkg::*;
  logic [7:0] mem [128]; // Contents
  // Preset, then apply write-backs
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h25);
  always @(posedge clk) if (wr.we) mem[wr.addr] <= wr.data;
  assign rdata = mem[addr];
  assign is_port = addr[6:1] == 6'h00;
  // Outside drive makes pins differ from the latch
  assign pins = rdata ^ 8'h5A;
endmodule
`default_nettype wire
